// >>> hdl/pll_clock_reset_sequencer.sv
// PLL mode control, clock output divider and reset/boot sequencing
`include "pll_seq_defines.svh"
`default_nettype none
module pll_clock_reset_sequencer #(
  parameter int unsigned LOCK_CYCLES = `LOCK_CYCLES
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [7:0]            awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [7:0]            araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  input  wire logic                  reset_pin_n,
  output logic                       reset_pin_out,
  output logic                       reset_pin_oe,
  input  wire logic                  pll_off_strap_n,
  input  wire logic [3:0]            boot_mode_pins,
  output logic                       system_clock_tick,
  output logic                       clock_output_pin,
  output pll_seq_pkg::pll_mode_t     pll_mode,
  output logic                       pll_locked,
  output logic                       bus_valid,
  output logic                       boot_done,
  output logic                       boot_to_rom,
  output logic [3:0]                 boot_mode,
  output logic                       max_rate_ok
);
  import pll_seq_pkg::*;

  localparam logic [17:0] LOCK_N = LOCK_CYCLES[17:0];

  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic        aw_full_q, w_full_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  pll_mode_t   pll_mode_q;
  seq_state_t  state_q;
  logic [3:0]  ratio_q, boot_mode_q;
  logic [1:0]  xcfg_q;
  logic [17:0] lock_cnt_q;
  logic        pll_locked_q, max_rate_q;
  logic [9:0]  wd_cnt_q;
  logic        reset_pin_oe_q, reset_pin_out_q;
  logic        sys_tick_q, clk_out_q;
  logic [2:0]  co_cnt_q;
  logic [10:0] seq_cnt_q;
  logic        bus_valid_q, boot_done_q, boot_to_rom_q;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire rst_cond  = !reset_pin_n || reset_pin_oe_q;
  wire aw_take   = awvalid && awready_q;
  wire w_take    = wvalid && wready_q;
  wire ar_take   = arvalid && arready_q;
  wire do_write  = aw_full_q && w_full_q && !bvalid_q;
  wire wa_ratio  = awaddr_q == `OFF_RATIO;
  wire wa_xcfg   = awaddr_q == `OFF_XCFG;
  wire wa_ctrl   = awaddr_q == `OFF_CTRL;
  wire wr_hit    = wa_ratio || wa_xcfg || wa_ctrl || awaddr_q == `OFF_STATUS;
  wire wr_low    = do_write && wstrb_q[0];
  // Ratio is frozen while reset runs or the PLL is strapped off
  wire wr_ratio  = wr_low && wa_ratio && !rst_cond && pll_mode_q != PLL_OFF;
  wire ratio_chg = wr_ratio && wdata_q[3:0] != ratio_q;
  wire wr_xcfg   = wr_low && wa_xcfg && !rst_cond;
  wire wr_ctrl   = wr_low && wa_ctrl;
  wire wd_start  = wr_ctrl && wdata_q[`CTRL_WD_BIT] && !reset_pin_oe_q;
  wire reboot    = wr_ctrl && wdata_q[`CTRL_REBOOT_BIT];

  wire [31:0] status_w = {20'h00000, boot_mode_q, 1'b0, max_rate_q, boot_to_rom_q,
                          boot_done_q, bus_valid_q, pll_locked_q, pll_mode_q};
  wire rd_hit = araddr == `OFF_RATIO || araddr == `OFF_XCFG ||
                araddr == `OFF_STATUS || araddr == `OFF_CTRL;
  wire [31:0] rd_word =
    (araddr == `OFF_RATIO)  ? {28'h0000000, ratio_q} :
    (araddr == `OFF_XCFG)   ? {30'h00000000, xcfg_q} :
    (araddr == `OFF_STATUS) ? status_w :
    (araddr == `OFF_CTRL)   ? {31'h00000000, reset_pin_oe_q} : 32'h00000000;

  // Clock output half period in input cycles: 2^(sysdiv+outdiv-1)
  wire [1:0] sh_w = {1'b0, pll_mode_q != PLL_OFF} + {1'b0, xcfg_q[`XCFG_TIM_BIT]} +
                    {1'b0, xcfg_q[`XCFG_MODE_BIT]};
  // Undivided output in strap-off mode is limited to input/2 here
  wire [2:0] half_w = (sh_w == 2'h3) ? 3'h4 : (sh_w == 2'h2) ? 3'h2 : 3'h1;
  wire       co_last = co_cnt_q >= half_w - 3'h1;

  ////////////////////////////////////////////////////////////////////////
  // Register bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
    end else begin
      awready_q <= awvalid && !awready_q && !aw_full_q && !bvalid_q;
      wready_q  <= wvalid && !wready_q && !w_full_q && !bvalid_q;
      arready_q <= arvalid && !arready_q && !rvalid_q;
      aw_full_q <= aw_take || (aw_full_q && !do_write);
      w_full_q  <= w_take || (w_full_q && !do_write);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end else begin
      if (aw_take) begin
        awaddr_q <= {awaddr[7:2], 2'h0};
      end
      if (w_take) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= `RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end else begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
        rdata_q  <= rd_word;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PLL mode, ratio and lock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_mode_q <= PLL_BYPASS;
      ratio_q    <= `RATIO_RST;
      xcfg_q     <= `XCFG_RST;
    end else if (rst_cond) begin
      pll_mode_q <= pll_off_strap_n ? PLL_BYPASS : PLL_OFF;
      ratio_q    <= `RATIO_RST;
      xcfg_q     <= `XCFG_RST;
    end else begin
      if (wr_ratio) begin
        ratio_q    <= wdata_q[3:0];
        pll_mode_q <= (wdata_q[3:0] != 4'h0) ? PLL_ON : PLL_BYPASS;
      end
      if (wr_xcfg) begin
        xcfg_q <= wdata_q[1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || rst_cond) begin
      lock_cnt_q   <= 18'h00000;
      pll_locked_q <= 1'b0;
    end else if (ratio_chg) begin
      lock_cnt_q   <= LOCK_N;
      pll_locked_q <= 1'b0;
    end else if (lock_cnt_q != 18'h00000) begin
      lock_cnt_q   <= lock_cnt_q - 18'h00001;
      pll_locked_q <= lock_cnt_q == 18'h00001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      max_rate_q <= 1'b0;
    end else begin
      max_rate_q <= pll_mode_q == PLL_ON && pll_locked_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog reset drive, open drain: pin only pulled low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_cnt_q        <= 10'h000;
      reset_pin_oe_q  <= 1'b0;
      reset_pin_out_q <= 1'b0;
    end else begin
      reset_pin_out_q <= 1'b0;
      if (wd_start) begin
        wd_cnt_q       <= `WD_CYCLES;
        reset_pin_oe_q <= 1'b1;
      end else if (reset_pin_oe_q) begin
        wd_cnt_q       <= wd_cnt_q - 10'h001;
        reset_pin_oe_q <= wd_cnt_q != 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // System clock ticks and clock output divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_tick_q <= 1'b0;
      co_cnt_q   <= 3'h0;
      clk_out_q  <= 1'b0;
    end else begin
      // tick every cycle or every other
      sys_tick_q <= pll_mode_q == PLL_OFF || !sys_tick_q;
      // outside strap-off mode, output is system clock over one, two or four, per the xcfg_q bits
      co_cnt_q   <= co_last ? 3'h0 : co_cnt_q + 3'h1;
      clk_out_q  <= co_last ? !clk_out_q : clk_out_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset release and boot sequence
  always_ff @(posedge aclk) begin
    if (!aresetn || rst_cond) begin
      state_q       <= SEQ_RESET;
      seq_cnt_q     <= 11'h000;
      bus_valid_q   <= 1'b0;
      boot_done_q   <= 1'b0;
      boot_to_rom_q <= 1'b0;
      boot_mode_q   <= 4'h0;
    end else begin
      case (state_q)
        SEQ_RESET: begin
          state_q   <= SEQ_WAKE;
          seq_cnt_q <= 11'h001;
        end
        SEQ_WAKE: begin
          seq_cnt_q <= seq_cnt_q + 11'h001;
          if (seq_cnt_q == `WAKE_CYCLES - 11'h001) begin
            bus_valid_q <= 1'b1;
            state_q     <= SEQ_BOOT;
            seq_cnt_q   <= 11'h000;
          end
        end
        SEQ_BOOT: begin
          if (sys_tick_q) begin
            seq_cnt_q <= seq_cnt_q + 11'h001;
            if (seq_cnt_q == `BOOT_TICKS - 11'h001) begin
              boot_mode_q   <= boot_mode_pins;
              boot_to_rom_q <= boot_mode_pins != `BOOT_MEM_CODE;
              boot_done_q   <= 1'b1;
              state_q       <= SEQ_RUN;
            end
          end
        end
        SEQ_RUN: begin
          if (reboot) begin
            state_q     <= SEQ_BOOT;
            seq_cnt_q   <= 11'h000;
            boot_done_q <= 1'b0;
          end
        end
        default: begin
          state_q <= SEQ_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign awready           = awready_q;
  assign wready            = wready_q;
  assign bvalid            = bvalid_q;
  assign bresp             = bresp_q;
  assign arready           = arready_q;
  assign rvalid            = rvalid_q;
  assign rdata             = rdata_q;
  assign rresp             = rresp_q;
  assign reset_pin_out     = reset_pin_out_q;
  assign reset_pin_oe      = reset_pin_oe_q;
  assign system_clock_tick = sys_tick_q;
  assign clock_output_pin  = clk_out_q;
  assign pll_mode          = pll_mode_q;
  assign pll_locked        = pll_locked_q;
  assign bus_valid         = bus_valid_q;
  assign boot_done         = boot_done_q;
  assign boot_to_rom       = boot_to_rom_q;
  assign boot_mode         = boot_mode_q;
  assign max_rate_ok       = max_rate_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks, with helper counters
  logic [17:0] lock_age_q;
  logic [9:0]  wd_len_q;
  logic [5:0]  rel_cnt_q;
  logic [11:0] boot_cyc_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_age_q <= 18'h00000;
      wd_len_q   <= 10'h000;
      rel_cnt_q  <= 6'h00;
      boot_cyc_q <= 12'h000;
    end else begin
      lock_age_q <= ratio_chg ? 18'h00000 :
                    (lock_cnt_q != 18'h00000) ? lock_age_q + 18'h00001 : lock_age_q;
      wd_len_q   <= reset_pin_oe_q ? wd_len_q + 10'h001 : 10'h000;
      rel_cnt_q  <= rst_cond ? 6'h00 : (rel_cnt_q == 6'h3F) ? rel_cnt_q : rel_cnt_q + 6'h01;
      boot_cyc_q <= (state_q == SEQ_BOOT) ? boot_cyc_q + 12'h001 : 12'h000;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_release;
    rst_cond ##1 !rst_cond;
  endsequence
  sequence s_enable;
    wr_ratio && wdata_q[3:0] != 4'h0;
  endsequence

  AST_OFF_TICK: assert property ((pll_mode_q == PLL_OFF) [*2] |-> sys_tick_q)
    else $error("strap-off mode lost a system tick");
  AST_STRAP_MODE: assert property (s_release |->
    pll_mode_q == ($past(pll_off_strap_n) ? PLL_BYPASS : PLL_OFF))
    else $error("mode after reset does not follow strap");
  AST_OFF_HOLD: assert property (!rst_cond && pll_mode_q == PLL_OFF |=> pll_mode_q == PLL_OFF)
    else $error("strap-off mode left without reset");
  AST_ENABLE: assert property (s_enable |=>
    pll_mode_q == PLL_ON && ratio_q == $past(wdata_q[3:0]) && !pll_locked_q)
    else $error("ratio write did not enable pll");
  AST_LOCK_TIME: assert property ($rose(pll_locked_q) |-> lock_age_q == LOCK_N)
    else $error("lock wait length wrong");
  AST_MAX_RATE: assert property (max_rate_q |-> $past(pll_mode_q) == PLL_ON)
    else $error("full rate claimed without pll");
  AST_WD_PULSE: assert property ($fell(reset_pin_oe_q) |-> wd_len_q == `WD_CYCLES)
    else $error("watchdog pulse length wrong");
  AST_WAKE: assert property ($rose(bus_valid_q) |-> rel_cnt_q == 6'h20)
    else $error("outputs valid at wrong time");
  // Strap-off mode has no halving stage, so input/8 becomes input/4 there
  AST_CFG_RESET: assert property (s_release |-> xcfg_q == `XCFG_RST ##1
    half_w == ((pll_mode_q == PLL_OFF) ? 3'h2 : 3'h4))
    else $error("clock output not input over eight");
  AST_BOOT_BYP: assert property ($rose(boot_done_q) && pll_mode_q == PLL_BYPASS |->
    boot_cyc_q inside {[2519:2520]})
    else $error("bypass boot length wrong");
  AST_BOOT_OFF: assert property ($rose(boot_done_q) && pll_mode_q == PLL_OFF |->
    boot_cyc_q == 12'h4EC)
    else $error("boot length does not follow system clock");
  AST_BRANCH: assert property ($rose(boot_done_q) |->
    boot_to_rom_q == ($past(boot_mode_pins) != `BOOT_MEM_CODE))
    else $error("boot branch does not match pins");
endmodule
`default_nettype wire

// >>> hdl/pll_seq_defines.svh
// Constants of the clock and reset sequencer
// Summary of operation
// - Strap low at reset: system clock equals input
// - Default after power-up: bypass, input halved
// - Non-zero ratio write enables PLL mode
// - Ratio change allows 131072 cycles for lock
// - Maximum clock rate only with PLL in use
// - Watchdog reset pulse lasts 512 input cycles
// - Outputs valid 32 cycles after reset release
// - Output divider bits reset to one, input/8 (input/4 when strapped off)
// - Boot waits 1260 system ticks, then samples
// - Sampled boot pins choose memory or loader
// - Rerun boot timing follows current system clock
`ifndef PLL_SEQ_DEFINES_SVH
`define PLL_SEQ_DEFINES_SVH

`define OFF_RATIO       8'h00
`define OFF_XCFG        8'h04
`define OFF_STATUS      8'h08
`define OFF_CTRL        8'h0C

`define RATIO_RST       4'h0
`define XCFG_TIM_BIT    0
`define XCFG_MODE_BIT   1
`define XCFG_RST        2'h3
`define CTRL_WD_BIT     0
`define CTRL_REBOOT_BIT 1
`define BOOT_MEM_CODE   4'hF

`define RESP_OKAY       2'h0
`define RESP_DECERR     2'h3

`define WAKE_CYCLES     11'h020
`define WD_CYCLES       10'h200
`define BOOT_TICKS      11'h4EC
`define LOCK_CYCLES     131072

`endif

// >>> hdl/pll_seq_pkg.sv
// Types shared by the clock and reset sequencer
`default_nettype none
package pll_seq_pkg;
  typedef enum logic [1:0] {PLL_OFF, PLL_BYPASS, PLL_ON} pll_mode_t;
  typedef enum logic [1:0] {SEQ_RESET, SEQ_WAKE, SEQ_BOOT, SEQ_RUN} seq_state_t;
endpackage
`default_nettype wire

// >>> test/board_model.sv
// Board side: reset driver on a pulled-up pin, PLL strap and boot straps
`default_nettype none
module board_model (
  input  wire logic       aclk,
  input  wire logic       oe,
  output wire logic       reset_pin_n,
  output logic            pll_off_strap_n,
  output logic [3:0]      boot_mode_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv_n = 1'h0;
  initial begin
    pll_off_strap_n = 1'h1;
    boot_mode_pins = 4'h0;
  end
  // Pulled up, so low whenever either side pulls it
  assign reset_pin_n = drv_n & ~oe;
  ////////////////////////////////////////////////////////////////////////////
  task automatic pulse(input logic strap, input logic [3:0] boot, input int len);
    @(posedge aclk);
    drv_n <= 1'h0;
    pll_off_strap_n <= strap;
    // boot straps kept until the next pulse
    boot_mode_pins <= boot;
    // pin held low for 8 cycles or more
    repeat (len < 8 ? 8 : len) @(posedge aclk);
    drv_n <= 1'h1;
  endtask
  task automatic set_strap(input logic s);
    @(posedge aclk);
    pll_off_strap_n <= s;
  endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench of the clock and reset sequencer
`include "pll_seq_defines.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pll_seq_pkg::*;
  localparam int LOCK = 20;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, reset_pin_n, reset_pin_out;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, v, d;
  logic        reset_pin_oe, pll_off_strap_n, system_clock_tick, clock_output_pin;
  logic [3:0]  boot_mode_pins, boot_mode;
  logic        pll_locked, bus_valid, boot_done, boot_to_rom, max_rate_ok;
  pll_mode_t   pll_mode;
  logic [31:0] seed = 32'h3F3A;
  int          error_cnt = 0;
  int          compares = 0;
  int          m_mode, m_xcfg, m_bm, m_rom, m_mx, n;

  always #50 aclk = ~aclk;

  pll_clock_reset_sequencer #(.LOCK_CYCLES(LOCK)) uut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .reset_pin_n(reset_pin_n), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .pll_off_strap_n(pll_off_strap_n), .boot_mode_pins(boot_mode_pins),
    .system_clock_tick(system_clock_tick), .clock_output_pin(clock_output_pin),
    .pll_mode(pll_mode), .pll_locked(pll_locked), .bus_valid(bus_valid),
    .boot_done(boot_done), .boot_to_rom(boot_to_rom), .boot_mode(boot_mode),
    .max_rate_ok(max_rate_ok));

  board_model brd (.aclk(aclk), .oe(reset_pin_oe), .reset_pin_n(reset_pin_n),
    .pll_off_strap_n(pll_off_strap_n), .boot_mode_pins(boot_mode_pins));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Locked bit is only known while max rate is expected
  function automatic logic [31:0] stx();
    return {20'h0, 4'(m_bm), 1'h0, 1'(m_mx), 1'(m_rom), 2'h3, 1'(m_mx), 2'(m_mode)};
  endfunction
  function automatic int exp_half();
    int s;
    s = (m_mode != 0) + m_xcfg[0] + m_xcfg[1];
    return (s == 0) ? 1 : (1 << (s - 1));
  endfunction
  function automatic logic pick(input int k);
    case (k)
      0: return bus_valid;
      1: return boot_done;
      2: return pll_locked;
      3: return reset_pin_oe;
      4: return clock_output_pin;
      5: return arready;
      6: return rvalid;
      default: return bvalid;
    endcase
  endfunction
  task automatic conclude();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Boot length allows a few cycles of tick phase slack
  task automatic near(input int c, input int e);
    compares++;
    if (c < e - 3 || c > e + 3) begin
      error_cnt++;
      $display("unexpected at %0t: count %0d want %0d", $time, c, e);
    end
  endtask
  task automatic waitv(input int k, input logic s, input int lim, output int c);
    c = 0;
    while (pick(k) !== s && c < lim) begin
      @(negedge aclk);
      c++;
    end
    if (pick(k) !== s) begin
      error_cnt++;
      $display("unexpected at %0t: wait %0d ran out", $time, k);
      conclude();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Ready is read at the falling edge, so the release edge is the taking one
  task automatic axw(input logic [7:0] a, input logic [31:0] x);
    int c;
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    wstrb <= 4'(rnd()) | 4'h1;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (c = 0; c < 50 && !(ad && wd); c++) begin
      @(negedge aclk);
      ad = ad | (awready === 1'h1);
      wd = wd | (wready === 1'h1);
      @(posedge aclk);
      if (ad) awvalid <= 1'h0;
      if (wd) wvalid <= 1'h0;
    end
    @(negedge aclk);
    waitv(7, 1'h1, 50, c);
    r = bresp;
    @(posedge aclk);
    bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a);
    int c;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    @(negedge aclk);
    waitv(5, 1'h1, 50, c);
    @(posedge aclk);
    arvalid <= 1'h0;
    @(negedge aclk);
    waitv(6, 1'h1, 50, c);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] msk);
    axr(a);
    chk(r, `RESP_OKAY);
    chk(d & msk, e & msk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    axw(a, x);
    chk(r, `RESP_OKAY);
  endtask
  task automatic half(input int e);
    int c;
    logic s;
    @(negedge aclk);
    s = clock_output_pin;
    waitv(4, ~s, 40, c);
    waitv(4, s, 40, c);
    chk(c, e);
  endtask
  task automatic ticks(input int e);
    int s;
    s = 0;
    repeat (4) begin
      @(negedge aclk);
      if (system_clock_tick === 1'h1) s++;
    end
    chk(s, e);
  endtask
  // Entered at the falling edge of the first cycle out of reset
  task automatic settle(input int bw);
    int c;
    waitv(0, 1'h1, 100, c);
    chk(c, 32); // wake delay
    waitv(1, 1'h1, 4000, c);
    near(c, bw); // boot wait
    rd(`OFF_STATUS, stx(), 32'hFFFFFFFB); // boot choice
  endtask
  task automatic start(input logic strap, input logic [3:0] bm, input int bw);
    brd.pulse(strap, bm, 8 + int'(rnd() % 8));
    m_mode = strap ? 1 : 0;
    m_bm = bm;
    m_rom = (bm != 4'hF);
    m_xcfg = 3;
    m_mx = 0;
    @(negedge aclk);
    settle(bw);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    v = rnd();
    start(1'h1, v[3:0], 2520);
    chk(pll_mode, m_mode); // bypass default
    ticks(2); // half rate
    rd(`OFF_XCFG, 32'h3, 32'hFFFFFFFF); // divider bits
    half(exp_half()); // output at input over 8
    rd(`OFF_RATIO, 32'h0, 32'hFFFFFFFF);
    axr(8'h10);
    chk(r, `RESP_DECERR);
    chk(d, 32'h0);
    axw(8'h14, rnd());
    chk(r, `RESP_DECERR);
    wr(`OFF_STATUS, rnd());
    v = rnd();
    n = (v[3:0] == 4'h0) ? 1 : v[3:0];
    wr(`OFF_RATIO, n); // ratio enables PLL
    m_mode = 2;
    chk(pll_mode, m_mode); // enabled mode
    @(negedge aclk);
    waitv(2, 1'h1, 4 * LOCK, n);
    near(n, LOCK); // lock wait
    repeat (2) @(negedge aclk);
    m_mx = 1;
    rd(`OFF_STATUS, stx(), 32'hFFFFFFFF); // max rate with PLL
    ticks(2); // system tick
    for (n = 0; n < 3; n++) begin
      v = (n == 0) ? 32'h0 : rnd();
      wr(`OFF_XCFG, v);
      m_xcfg = v[1:0];
      rd(`OFF_XCFG, m_xcfg, 32'hFFFFFFFF);
      half(exp_half()); // divider setting
    end
    wr(`OFF_RATIO, 32'h0);
    m_mode = 1;
    m_mx = 0;
    chk(pll_mode, m_mode); // zero ratio bypass
    wr(`OFF_CTRL, 32'h2);
    @(negedge aclk);
    waitv(1, 1'h0, 10, n);
    waitv(1, 1'h1, 4000, n);
    near(n, 2520); // rerun on current clock
    wr(`OFF_CTRL, 32'h1);
    @(negedge aclk);
    waitv(3, 1'h1, 10, n);
    waitv(3, 1'h0, 600, n);
    // Pulse began at the response edge, one cycle before counting started
    chk(n + 1, 512); // watchdog pulse
    m_xcfg = 3;
    settle(2520);
    rd(`OFF_XCFG, 32'h3, 32'hFFFFFFFF); // reset value again
    rd(`OFF_RATIO, 32'h0, 32'hFFFFFFFF);
    start(1'h0, 4'hF, 1260); // memory boot
    ticks(4); // full rate
    half(exp_half()); // off mode divider
    wr(`OFF_RATIO, 32'h5);
    rd(`OFF_RATIO, 32'h0, 32'hFFFFFFFF);
    chk(pll_mode, 0); // ratio ignored
    brd.set_strap(1'h1);
    repeat (20) @(negedge aclk);
    chk(pll_mode, 0); // mode kept
    conclude();
  end
endmodule
`default_nettype wire
